//--- src/ascr_host_end.sv
`timescale 1ns/1ps
`default_nettype none

module ascr_host_end
    import ascr_pkg::*;
#(
    parameter int CHAIN_LEN = 1,
    parameter int SCLK_HALF = 4,
    parameter int CONV_WAIT = CONV_CYC
) (
    // serial link
    ascr_link_if.host         link,
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // register port
    input  wire logic [7:0]   regAddr,
    input  wire logic [31:0]  regWdata,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output logic      [31:0]  regRdata
);

    // half period of 4 leaves room for the sync delay on both ends
    if (CHAIN_LEN < 1 || CHAIN_LEN > 4 || SCLK_HALF < 4 || SCLK_HALF > 255
        || 2 * SCLK_HALF * CLK_NS < SCLK_MIN_NS
        || CONV_WAIT < 1 || CONV_WAIT > 65534) begin : g_bad_param
        $error("host parameters out of range");
    end

    localparam int CFG_BITS = CFG_W * CHAIN_LEN;
    localparam int RD_BITS  = RES_W * CHAIN_LEN;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_CFG_ARM  = 3'b001,
        ST_CFG_SEL  = 3'b011,
        ST_CFG_SHFT = 3'b010,
        ST_RISE     = 3'b110,
        ST_QUIET    = 3'b111,
        ST_RD_WAIT  = 3'b100,
        ST_RD_SHFT  = 3'b101
    } ascr_host_state_e;

    ascr_host_state_e   state_r;
    logic [15:0]        tmr_r;
    logic [7:0]         bitCnt_r;
    logic [15:0]        sinceRise_r;
    logic               sclk_r;
    logic               cs_r;
    logic               din_r;
    logic               isCfg_r;
    logic               done_r;
    logic [CFG_W-1:0]   cfgByte_r;
    logic [CFG_W-1:0]   txShift_r;
    logic [1:0]         modeUsed_r;
    logic [RD_BITS-1:0] res_r;
    logic               doutLvl;
    logic               startCfg;
    logic               startConv;
    logic               tmrZero;
    logic               busyCs;
    logic [7:0]         rdLast;
    logic [CFG_W-1:0]   cfgTx;

    ascr_sync_edge #(.INIT(1'b1)) u_dout (
        .clk   (clk),
        .reset (reset),
        .async (link.dout),
        .level (doutLvl),
        .rise  (),
        .fall  ()
    );

    assign startCfg  = regWr && regAddr == REG_CTRL && regWdata[CTRL_CFG] && state_r == ST_IDLE;
    assign startConv = regWr && regAddr == REG_CTRL && regWdata[CTRL_CONV] && !regWdata[CTRL_CFG]
                       && state_r == ST_IDLE;
    assign tmrZero   = tmr_r == 16'h0000;
    assign busyCs    = modeUsed_r == MODE_CS_BUSY;
    assign rdLast    = busyCs ? 8'(RD_BITS) : 8'(RD_BITS - 1);
    assign cfgTx     = cfgByte_r & ~CFG_RSVD_MASK;

    ////////////////////////////////////////////////////////////////////////
    // link sequencer

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r   <= ST_IDLE;
            tmr_r     <= 16'h0000;
            bitCnt_r  <= 8'h00;
            sclk_r    <= 1'b0;
            cs_r      <= 1'b1;
            din_r     <= 1'b1;
            isCfg_r   <= 1'b0;
            txShift_r <= CFG_DEFAULT;
            res_r     <= '0;
        end else begin
            if (!tmrZero) begin
                tmr_r <= tmr_r - 16'h0001;
            end
            case (state_r)
                ST_IDLE: begin
                    sclk_r <= 1'b0;
                    din_r  <= 1'b1;
                    if (startCfg) begin
                        sclk_r  <= 1'b1;
                        isCfg_r <= 1'b1;
                        tmr_r   <= 16'(SCLK_HALF - 1);
                        state_r <= ST_CFG_ARM;
                    end else if (startConv) begin
                        isCfg_r <= 1'b0;
                        state_r <= ST_RD_WAIT;
                    end
                end
                ST_CFG_ARM: if (tmrZero) begin
                    cs_r    <= 1'b0;
                    tmr_r   <= 16'(SCLK_HALF - 1);
                    state_r <= ST_CFG_SEL;
                end
                ST_CFG_SEL: if (tmrZero) begin
                    din_r     <= cfgTx[CFG_W-1];
                    txShift_r <= {cfgTx[CFG_W-2:0], cfgTx[CFG_W-1]};
                    bitCnt_r  <= 8'h00;
                    tmr_r     <= 16'(SCLK_HALF - 1);
                    state_r   <= ST_CFG_SHFT;
                end
                ST_CFG_SHFT: if (tmrZero) begin
                    tmr_r <= 16'(SCLK_HALF - 1);
                    if (sclk_r) begin
                        sclk_r <= 1'b0;
                    end else if (bitCnt_r == 8'(CFG_BITS - 1)) begin
                        din_r   <= 1'b1;
                        tmr_r   <= 16'(QB_CYC - 1);
                        state_r <= ST_RISE;
                    end else begin
                        // the byte rotates so every chained device gets it
                        sclk_r    <= 1'b1;
                        din_r     <= txShift_r[CFG_W-1];
                        txShift_r <= {txShift_r[CFG_W-2:0], txShift_r[CFG_W-1]};
                        bitCnt_r  <= bitCnt_r + 8'h01;
                    end
                end
                ST_RD_WAIT: begin
                    if (busyCs) begin
                        cs_r <= 1'b0;
                    end
                    if ((busyCs && (!doutLvl || sinceRise_r == 16'hffff))
                        || (!busyCs && sinceRise_r >= 16'(CONV_WAIT))) begin
                        cs_r     <= 1'b0;
                        bitCnt_r <= 8'h00;
                        tmr_r    <= 16'(SCLK_HALF - 1);
                        state_r  <= ST_RD_SHFT;
                    end
                end
                ST_RD_SHFT: if (tmrZero) begin
                    tmr_r <= 16'(SCLK_HALF - 1);
                    if (!sclk_r) begin
                        sclk_r <= 1'b1;
                    end else begin
                        res_r  <= {res_r[RD_BITS-2:0], doutLvl};
                        sclk_r <= 1'b0;
                        if (bitCnt_r == rdLast) begin
                            tmr_r   <= 16'(QB_CYC - 1);
                            state_r <= ST_RISE;
                        end else begin
                            bitCnt_r <= bitCnt_r + 8'h01;
                        end
                    end
                end
                ST_RISE: if (tmrZero) begin
                    cs_r    <= 1'b1;
                    tmr_r   <= 16'(QA_CYC - 1);
                    state_r <= ST_QUIET;
                end
                ST_QUIET: if (tmrZero) begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion age, mode in use and completion

    always_ff @(posedge clk) begin
        if (reset || (state_r == ST_RISE && tmrZero)) begin
            sinceRise_r <= 16'h0000;
        end else if (sinceRise_r != 16'hffff) begin
            sinceRise_r <= sinceRise_r + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            modeUsed_r <= CFG_DEFAULT[MODE_HI:MODE_LO];
            done_r     <= 1'b0;
        end else if (startCfg || startConv) begin
            done_r <= 1'b0;
        end else if (state_r == ST_QUIET && tmrZero) begin
            done_r <= 1'b1;
            if (isCfg_r) begin
                // a power-down byte sends the device back to defaults
                modeUsed_r <= cfgTx[PD_BIT] ? CFG_DEFAULT[MODE_HI:MODE_LO] : cfgTx[MODE_HI:MODE_LO];
            end
        end
    end

    assign link.sclk               = sclk_r;
    assign link.convertStartSelect = cs_r;
    assign link.din                = din_r;

    ////////////////////////////////////////////////////////////////////////
    // register port

    logic [31:0] rd_nxt;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfgByte_r <= CFG_DEFAULT;
        end else if (regWr && regAddr == REG_CFG) begin
            cfgByte_r <= regWdata[CFG_W-1:0];
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (regAddr == REG_CFG) begin
            rd_nxt[CFG_W-1:0] = cfgByte_r;
        end else if (regAddr == REG_STATUS) begin
            rd_nxt[ST_BUSY]                 = state_r != ST_IDLE;
            rd_nxt[ST_DONE]                 = done_r;
            rd_nxt[ST_MODE_LO+1:ST_MODE_LO] = modeUsed_r;
        end
        for (int i = 0; i < CHAIN_LEN; i++) begin
            if (regAddr == REG_RES0 + 8'(4 * i)) begin
                rd_nxt[RES_W-1:0] = res_r[RD_BITS-1-RES_W*i -: RES_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRd ? rd_nxt : 32'h0000_0000;
        end
    end

endmodule // ascr_host_end

`default_nettype wire

//--- src/ascr_pkg.sv
package ascr_pkg;

    // configuration byte layout
    localparam int CFG_W     = 8;
    localparam int MODE_HI   = 7;
    localparam int MODE_LO   = 6;
    localparam int DAISY_BIT = 7;
    localparam int REF_HI    = 5;
    localparam int REF_LO    = 4;
    localparam int PD_BIT    = 3;
    localparam logic [CFG_W-1:0] CFG_DEFAULT   = 8'h00;
    localparam logic [CFG_W-1:0] CFG_RSVD_MASK = 8'h07;
    localparam logic [3:0]       CFG_CNT_FULL  = 4'h8;
    localparam logic [1:0]       MODE_CS_BUSY  = 2'h1;

    // conversion result
    localparam int RES_W = 16;

    // timing
    localparam int CLK_NS          = 10;
    localparam int SCLK_MIN_NS     = 20;
    localparam int QUIET_BEFORE_NS = 25;
    localparam int QUIET_AFTER_NS  = 10;
    localparam int CONV_TIME_NS    = 2000;
    localparam int QB_CYC   = (QUIET_BEFORE_NS + CLK_NS - 1) / CLK_NS;
    localparam int QA_CYC   = (QUIET_AFTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;

    // host controller register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RES0   = 8'h10;
    localparam int CTRL_CFG   = 0;
    localparam int CTRL_CONV  = 1;
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_MODE_LO = 2;

endpackage

//--- src/ascr_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ascr_link_if;
    logic sclk;
    logic convertStartSelect;
    logic din;
    logic doutO;
    logic doutOe;
    logic dout;

    // data-out idles high through the external pull-up
    assign dout = doutOe ? doutO : 1'b1;

    modport device (input sclk, input convertStartSelect, input din, output doutO, output doutOe);
    modport host   (output sclk, output convertStartSelect, output din, input dout);
endinterface

`default_nettype wire

//--- src/ascr_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none

module ascr_sync_edge #(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin side
    input  wire logic async,
    // clocked side
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= INIT;
            sync_r <= INIT;
            prev_r <= INIT;
        end else begin
            meta_r <= async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;
endmodule // ascr_sync_edge

`default_nettype wire

//--- src/ascr_adc_end.sv
// How it works
// - host keeps serial clock at most 50 MHz
// - config bits sampled on serial clock falls
// - select falling with clock high enters config
// - chip-select mode captures exactly eight falls
// - select rising ends the config load
// - host idles data-in high
// - bits 7:6 choose output interface mode
// - bits 5:4 choose reference power
// - bit 3 power-down, bits 2:0 zero
// - power-down write restores all defaults
// - daisy chain: config is 8-bit shift stage
// - host gives eight falls per chained device
// - new config applies at next conversion
// - no-busy modes: host waits conversion time
// - busy modes: data-out low means ready
// - host keeps inputs quiet around select rise
// - data-out stable across both clock edges (code: at the default half period of 4 it changes on the rise)
// - host idles serial clock low
// - leftover unread bits go out first
// - host reads every bit before new ones
// - select rise starts conversion, releases data-out except in daisy chain
// - no-busy mode releases after sixteenth fall
`timescale 1ns/1ps
`default_nettype none

module ascr_adc_end
    import ascr_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // serial link
    ascr_link_if.device          link,
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // converter core
    input  wire logic [RES_W-1:0] convResult,
    output logic                  convStart,
    output logic                  converting,
    // active settings
    output logic [1:0]            activeMode,
    output logic [1:0]            refMode,
    output logic                  powerDown
);

    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
        $error("CONV_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic sclkLvl;
    logic sclkFall;
    logic csLvl;
    logic csRise;
    logic csFall;
    logic dinLvl;

    ascr_sync_edge #(.INIT(1'b0)) u_sclk (
        .clk   (clk),
        .reset (reset),
        .async (link.sclk),
        .level (sclkLvl),
        .rise  (),
        .fall  (sclkFall)
    );

    ascr_sync_edge #(.INIT(1'b1)) u_cs (
        .clk   (clk),
        .reset (reset),
        .async (link.convertStartSelect),
        .level (csLvl),
        .rise  (csRise),
        .fall  (csFall)
    );

    // data-in shares the sclk delay, so it is sampled as it stood at the fall
    ascr_sync_edge #(.INIT(1'b1)) u_din (
        .clk   (clk),
        .reset (reset),
        .async (link.din),
        .level (dinLvl),
        .rise  (),
        .fall  ()
    );

    ////////////////////////////////////////////////////////////////////////
    // configuration write

    logic             cfgWr_r;
    logic [3:0]       cfgCnt_r;
    logic [CFG_W-1:0] cfgShift_r;
    logic [CFG_W-1:0] cfgPend_r;
    logic             cfgPendV_r;
    logic [CFG_W-1:0] cfg_r;
    logic             pd_r;
    logic             daisy;
    logic             cfgEnter;
    logic             applyCfg;
    logic             pdAfter;

    assign daisy    = cfg_r[DAISY_BIT];
    assign cfgEnter = csFall && sclkLvl;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfgWr_r    <= 1'b0;
            cfgCnt_r   <= 4'h0;
            cfgShift_r <= CFG_DEFAULT;
        end else if (cfgEnter) begin
            cfgWr_r  <= 1'b1;
            cfgCnt_r <= 4'h0;
        end else if (csRise) begin
            cfgWr_r <= 1'b0;
        end else if (cfgWr_r && sclkFall && (daisy || cfgCnt_r != CFG_CNT_FULL)) begin
            // daisy chain keeps shifting so upstream bytes pass through
            cfgShift_r <= {cfgShift_r[CFG_W-2:0], dinLvl};
            if (cfgCnt_r != CFG_CNT_FULL) begin
                cfgCnt_r <= cfgCnt_r + 4'h1;
            end
        end
    end

    // a short load in chip-select mode is dropped, not half applied
    always_ff @(posedge clk) begin
        if (reset) begin
            cfgPend_r  <= CFG_DEFAULT;
            cfgPendV_r <= 1'b0;
        end else if (csRise && cfgWr_r && cfgCnt_r == CFG_CNT_FULL) begin
            cfgPend_r  <= cfgShift_r;
            cfgPendV_r <= 1'b1;
        end else if (applyCfg) begin
            cfgPendV_r <= 1'b0;
        end
    end

    assign applyCfg = csRise && !cfgWr_r && cfgPendV_r;
    assign pdAfter  = cfgPendV_r ? cfgPend_r[PD_BIT] : pd_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= CFG_DEFAULT;
            pd_r  <= 1'b0;
        end else if (applyCfg) begin
            if (cfgPend_r[PD_BIT]) begin
                cfg_r <= CFG_DEFAULT;
                pd_r  <= 1'b1;
            end else begin
                cfg_r <= cfgPend_r;
                pd_r  <= 1'b0;
            end
        end
    end

    assign activeMode = cfg_r[MODE_HI:MODE_LO];
    assign refMode    = cfg_r[REF_HI:REF_LO];
    assign powerDown  = pd_r;

    ////////////////////////////////////////////////////////////////////////
    // conversion timing

    logic [15:0] convCnt_r;
    logic        converting_r;
    logic        convDone;

    // the rise that closes a config load starts no conversion
    assign convStart = csRise && !cfgWr_r && !converting_r && !pdAfter;
    assign convDone  = converting_r && convCnt_r == 16'h0000;

    always_ff @(posedge clk) begin
        if (reset) begin
            converting_r <= 1'b0;
            convCnt_r    <= 16'h0000;
        end else if (convStart) begin
            converting_r <= 1'b1;
            convCnt_r    <= 16'(CONV_CYCLES - 1);
        end else if (convDone) begin
            converting_r <= 1'b0;
        end else if (converting_r) begin
            convCnt_r <= convCnt_r - 16'h0001;
        end
    end

    assign converting = converting_r;

    ////////////////////////////////////////////////////////////////////////
    // result readout

    logic [RES_W-1:0] outShift_r;
    logic [RES_W-1:0] newRes_r;
    logic             newResV_r;
    logic [4:0]       bitsLeft_r;
    logic             busyHold_r;
    logic             readEn;
    logic             csShift;
    logic             dcShift;

    assign readEn  = !csLvl && !converting_r && !cfgWr_r && !pd_r;
    assign csShift = sclkFall && readEn && !daisy && (busyHold_r || bitsLeft_r != 5'h00);
    assign dcShift = sclkFall && readEn && daisy;

    always_ff @(posedge clk) begin
        if (reset) begin
            outShift_r <= '0;
            newRes_r   <= '0;
            newResV_r  <= 1'b0;
            bitsLeft_r <= 5'h00;
            busyHold_r <= 1'b0;
        end else if (applyCfg && cfgPend_r[PD_BIT]) begin
            newResV_r  <= 1'b0;
            bitsLeft_r <= 5'h00;
            busyHold_r <= 1'b0;
        end else if (convDone) begin
            // an unfinished word keeps the line; the new one waits behind it
            if (bitsLeft_r == 5'h00) begin
                outShift_r <= convResult;
                bitsLeft_r <= 5'(RES_W);
            end else begin
                newRes_r  <= convResult;
                newResV_r <= 1'b1;
            end
            busyHold_r <= (activeMode == MODE_CS_BUSY);
        end else if (csShift) begin
            if (busyHold_r) begin
                busyHold_r <= 1'b0;
            end else begin
                outShift_r <= {outShift_r[RES_W-2:0], 1'b0};
                bitsLeft_r <= bitsLeft_r - 5'h01;
            end
        end else if (dcShift) begin
            outShift_r <= {outShift_r[RES_W-2:0], dinLvl};
            if (bitsLeft_r != 5'h00) begin
                bitsLeft_r <= bitsLeft_r - 5'h01;
            end
        end else if (csRise && bitsLeft_r == 5'h00 && newResV_r) begin
            outShift_r <= newRes_r;
            bitsLeft_r <= 5'(RES_W);
            newResV_r  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data-out driver

    logic doutO_r;
    logic doutO_nxt;
    logic doutOe_r;
    logic doutOe_nxt;

    always_comb begin
        doutO_nxt  = 1'b1;
        doutOe_nxt = 1'b0;
        if (pd_r) begin
            doutOe_nxt = 1'b0;
        end else if (daisy) begin
            doutOe_nxt = 1'b1;
            doutO_nxt  = cfgWr_r ? cfgShift_r[CFG_W-1] : outShift_r[RES_W-1];
        end else begin
            // conversion or a high select line float the pin
            doutOe_nxt = readEn && (busyHold_r || bitsLeft_r != 5'h00);
            doutO_nxt  = busyHold_r ? 1'b0 : outShift_r[RES_W-1];
        end
    end

    // registered so each bit holds from one fall to the next
    always_ff @(posedge clk) begin
        if (reset) begin
            doutO_r  <= 1'b1;
            doutOe_r <= 1'b0;
        end else begin
            doutO_r  <= doutO_nxt;
            doutOe_r <= doutOe_nxt;
        end
    end

    assign link.doutO  = doutO_r;
    assign link.doutOe = doutOe_r;

endmodule // ascr_adc_end

`default_nettype wire

//--- tb/ascr_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module ascr_link_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // serial link
    input wire logic sclk,
    input wire logic convertStartSelect,
    input wire logic din,
    input wire logic doutO,
    input wire logic doutOe
);
    logic       cfgOn_r;
    logic [3:0] falls_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence csRise;
        $rose(convertStartSelect);
    endsequence
    sequence csHigh;
        convertStartSelect [*6];
    endsequence
    ////////////////////////////////////////////////////////////////
    // counts falls between a config entry and the select rise
    always_ff @(posedge clk) begin
        if (reset) begin
            cfgOn_r <= 1'b0;
            falls_r <= 4'h0;
        end else if ($fell(convertStartSelect) && sclk) begin
            cfgOn_r <= 1'b1;
            falls_r <= 4'h0;
        end else if ($rose(convertStartSelect)) begin
            cfgOn_r <= 1'b0;
        end else if (cfgOn_r && $fell(sclk)) begin
            falls_r <= falls_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_idle: assert property ($fell(reset) |-> !sclk && convertStartSelect && din && !doutOe)
        else $error("link not idle after reset");
    a_din_idle: assert property (!din |-> !convertStartSelect)
        else $error("data-in low outside a load");
    a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*3])
        else $error("serial clock half period too short");
    a_cfg_falls: assert property (csRise and cfgOn_r |-> falls_r == 4'h8)
        else $error("config load without eight falls");
    a_dout_release: assert property (csRise |-> ##[1:6] !doutOe)
        else $error("data-out not released after select rise");
    a_dout_idle: assert property (csHigh |-> !doutOe)
        else $error("data-out driven while deselected");
    a_dout_stable: assert property ($fell(sclk) && doutOe |-> $stable(doutO))
        else $error("data-out moved at a clock fall");
    a_quiet_select: assert property (csRise |-> sclk == $past(sclk, 3) && din == $past(din, 3)
        ##1 $stable(sclk) && $stable(din))
        else $error("link inputs moved near select rise");
endmodule // ascr_link_assertions

`default_nettype wire

//--- tb/adc_serial_config_readout_test.sv
`timescale 1ns/1ps
`default_nettype none

module adc_serial_config_readout_test;
    import ascr_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, d;
    logic [15:0] convResult = 16'h0;
    logic        convStart, converting, powerDown;
    logic [1:0]  activeMode, refMode;
    int          n_errors = 0, tests_run = 0, cyc = 0;
    logic [15:0] q[$];
    ascr_link_if link ();
    ascr_adc_end #(.CONV_CYCLES(20)) ascr_adc_end_inst (.link(link.device), .clk(clk), .reset(reset),
        .convResult(convResult), .convStart(convStart), .converting(converting), .activeMode(activeMode),
        .refMode(refMode), .powerDown(powerDown));
    ascr_host_end #(.CONV_WAIT(20)) ascr_host_end_inst (.link(link.host), .clk(clk), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    ascr_link_assertions ascr_link_assertions_inst (.clk(clk), .reset(reset), .sclk(link.sclk),
        .convertStartSelect(link.convertStartSelect), .din(link.din), .doutO(link.doutO), .doutOe(link.doutOe));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang must still reach the verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] st();
        return {11'h0, powerDown, activeMode, refMode};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask
    task automatic go(input logic [31:0] c);
        wr(REG_CTRL, c);
        d = 32'h0;
        for (int i = 0; i < 400 && d[ST_DONE] !== 1'b1; i++) rd(REG_STATUS);
        if (d[ST_DONE] !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t link transfer never finished", $time);
        end
    endtask
    task automatic cfg(input logic [7:0] b);
        wr(REG_CFG, {24'h0, b});
        rd(REG_CFG);
        chk(d[15:0], {8'h00, b});
        go(32'h1);
    endtask
    // model: results queue in conversion order, all ones when nothing is pending
    task automatic readout(input bit conv, input logic [15:0] keep = 16'hffff);
        logic [15:0] e, v;
        e = (q.size() > 0) ? q.pop_front() : 16'hffff;
        v = 16'($urandom) & keep;
        convResult <= v;
        go(32'h2);
        rd(REG_RES0);
        chk(d[15:0], e);
        // the result word must hold until the conversion it feeds has ended
        repeat (30) @(posedge clk);
        if (conv) q.push_back(v);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(63));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk(st(), 16'h0);
        rd(8'h3c);
        chk(d[15:0], 16'h0);
        $display("reset defaults done");
        cfg(8'h20);
        chk(st(), 16'h0);
        readout(1'b1);
        chk(st(), 16'h2);
        readout(1'b1);
        readout(1'b1);
        $display("config and readout done");
        cfg(8'hf8);
        chk(st(), 16'h2);
        readout(1'b0);
        chk(st(), 16'h10);
        cfg(8'h10);
        chk(st(), 16'h10);
        readout(1'b1, 16'h7fff);
        chk(st(), 16'h1);
        $display("power-down done");
        for (int m = 1; m < 4; m++) begin
            cfg({m[1:0], 6'h0});
            chk(st(), 16'h1);
        end
        cfg(8'h50);
        chk(d[15:0], 16'h0006);
        // host waits on busy one readout before the device does: msb taken as busy
        q[0] = {q[0][14:0], 1'b1};
        readout(1'b1);
        chk(st(), 16'h5);
        readout(1'b1);
        $display("mode loads done");
        end_of_test();
    end
endmodule // adc_serial_config_readout_test

`default_nettype wire
